// File: bench/slr_checker.sv
/*
 Assertion checker for slr_top, watching its ports only.
 Assumes one clock, a synchronous active-low reset and a window of 5 steps or more.
*/
`timescale 1ns/1ps
`default_nettype none
module slr_checker #(
    parameter [15:0] MAX_TORQUE = 16'h0BB8
) (
    // Clock and reset
    input wire logic               CLK_SYS_IN,
    input wire logic               RST_N_IN,
    // Inputs watched
    input wire logic               WR_IN,
    input wire logic               TORQUE_MODE_IN,
    input wire logic               SERVO_ON_IN,
    input wire logic signed [15:0] TORQUE_REF_IN,
    input wire logic signed [15:0] MOTOR_SPEED_IN,
    // Outputs watched
    input wire logic        [15:0] POS_TORQUE_LIMIT_OUT,
    input wire logic        [15:0] NEG_TORQUE_LIMIT_OUT,
    input wire logic        [15:0] POS_SPEED_LIMIT_OUT,
    input wire logic        [15:0] NEG_SPEED_LIMIT_OUT,
    input wire logic signed [15:0] SPEED_CMD_OUT,
    input wire logic               TORQUE_REACHED_OUT,
    input wire logic               SPEED_LIMITED_OUT
);
    // Shortest over-limit run before the flag, less pipeline skew
    localparam int MIN_RUN = 19990;
    logic [15:0] spd_abs;
    logic        qual;
    logic [15:0] run_q;
    logic [15:0] run_d;

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);

    assign spd_abs = MOTOR_SPEED_IN[15] ? 16'h0000 - MOTOR_SPEED_IN : MOTOR_SPEED_IN;
    assign qual    = TORQUE_MODE_IN && SERVO_ON_IN
        && (spd_abs > (MOTOR_SPEED_IN[15] ? NEG_SPEED_LIMIT_OUT : POS_SPEED_LIMIT_OUT));
    assign run_d   = !qual ? 16'h0000 : (&run_q) ? run_q : run_q + 16'h0001;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            run_q <= 16'h0000;
        end else begin
            run_q <= run_d;
        end
    end

    a_torque_clamped: assert property (
        POS_TORQUE_LIMIT_OUT <= MAX_TORQUE && NEG_TORQUE_LIMIT_OUT <= MAX_TORQUE)
        else $error("torque limit above drive maximum");
    a_speed_range: assert property (
        POS_SPEED_LIMIT_OUT <= 16'h1770 && NEG_SPEED_LIMIT_OUT <= 16'h1770)
        else $error("speed limit above setting range");
    a_cmd_within: assert property (
        TORQUE_MODE_IN && $stable(POS_SPEED_LIMIT_OUT) && $stable(NEG_SPEED_LIMIT_OUT)
        ##1 TORQUE_MODE_IN && $stable(POS_SPEED_LIMIT_OUT) && $stable(NEG_SPEED_LIMIT_OUT)
        |-> SPEED_CMD_OUT <= $signed({1'b0, POS_SPEED_LIMIT_OUT})
        && SPEED_CMD_OUT >= -$signed({1'b0, NEG_SPEED_LIMIT_OUT}))
        else $error("speed command outside limits");
    a_reach_steady: assert property (
        (!WR_IN && $stable(TORQUE_REF_IN))[*3] |-> $stable(TORQUE_REACHED_OUT))
        else $error("torque reached moved with steady reference");
    a_limited_late: assert property (
        $rose(SPEED_LIMITED_OUT) |-> run_q >= MIN_RUN)
        else $error("speed limited set before window ran out");
    a_limited_cause: assert property (
        SPEED_LIMITED_OUT |-> $past(qual))
        else $error("speed limited high without over-limit speed");
    a_limited_drop: assert property (
        $fell(SPEED_LIMITED_OUT) |-> !$past(qual))
        else $error("speed limited fell while still over limit");
    a_limited_mode: assert property (
        !(TORQUE_MODE_IN && SERVO_ON_IN) |=> !SPEED_LIMITED_OUT)
        else $error("speed limited high outside torque mode or servo on");

    c_limited: cover property ($rose(SPEED_LIMITED_OUT));
    c_reached: cover property ($rose(TORQUE_REACHED_OUT));
    c_released: cover property ($fell(TORQUE_REACHED_OUT));
endmodule

bind slr_top slr_checker #(.MAX_TORQUE(MAX_TORQUE)) i_checker (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .WR_IN(WR_IN),
    .TORQUE_MODE_IN(TORQUE_MODE_IN), .SERVO_ON_IN(SERVO_ON_IN),
    .TORQUE_REF_IN(TORQUE_REF_IN), .MOTOR_SPEED_IN(MOTOR_SPEED_IN),
    .POS_TORQUE_LIMIT_OUT(POS_TORQUE_LIMIT_OUT), .NEG_TORQUE_LIMIT_OUT(NEG_TORQUE_LIMIT_OUT),
    .POS_SPEED_LIMIT_OUT(POS_SPEED_LIMIT_OUT), .NEG_SPEED_LIMIT_OUT(NEG_SPEED_LIMIT_OUT),
    .SPEED_CMD_OUT(SPEED_CMD_OUT), .TORQUE_REACHED_OUT(TORQUE_REACHED_OUT),
    .SPEED_LIMITED_OUT(SPEED_LIMITED_OUT)
);
`default_nettype wire

// File: bench/slr_host_model.sv
/*
 Host controller model: drives the speed limit select input, counts reached pulses.
 Assumes the drive clock and its synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module slr_host_model (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Host request and drive outputs
    input  wire logic       sel_req_in,
    input  wire logic       reached_in,
    output var  logic       select_out,
    output var  logic [7:0] reach_rise_out
);
    logic       sel_q;
    logic       seen_q;
    logic [7:0] rise_q;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sel_q  <= 1'b0;
            seen_q <= 1'b0;
            rise_q <= 8'h00;
        end else begin
            sel_q  <= sel_req_in;
            seen_q <= reached_in;
            rise_q <= rise_q + {7'h00, reached_in && !seen_q};
        end
    end
    assign select_out     = sel_q;
    assign reach_rise_out = rise_q;
endmodule
`default_nettype wire

// File: bench/slr_testbench.sv
/*
 Self-checking bench for slr_top: registers, limit selection and status flags.
 Assumes the checker is bound to the design and the host model drives the select input.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        tmode = 1'b0, son = 1'b0, sel_req = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000, tref = 16'h0000, mspd = 16'h0000, sref = 16'h0000;
    logic [15:0] ai1 = 16'h03E8, ai2 = 16'h09C4, atl = 16'h04B0;
    logic        sel, reached, limited, irq;
    logic [7:0]  rises;
    logic [15:0] rdata, ptl, ntl, psl, nsl, scmd;
    int          fail_count = 0;
    int          check_count = 0;

    always #12.5 clk = ~clk;

    slr_top #(.MAX_TORQUE(16'h09C4)) i_dut (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .TORQUE_MODE_IN(tmode),
        .SERVO_ON_IN(son), .SPEED_LIMIT_SELECT_IN(sel), .TORQUE_REF_IN(tref),
        .MOTOR_SPEED_IN(mspd), .SPEED_REF_IN(sref), .ANALOG_INPUT_ONE_IN(ai1),
        .ANALOG_INPUT_TWO_IN(ai2), .ANALOG_TORQUE_LIMIT_IN(atl),
        .POS_TORQUE_LIMIT_OUT(ptl), .NEG_TORQUE_LIMIT_OUT(ntl), .POS_SPEED_LIMIT_OUT(psl),
        .NEG_SPEED_LIMIT_OUT(nsl), .SPEED_CMD_OUT(scmd), .TORQUE_REACHED_OUT(reached),
        .SPEED_LIMITED_OUT(limited), .IRQ_OUT(irq));
    slr_host_model i_host (.clk_in(clk), .rst_n_in(rst_n), .sel_req_in(sel_req),
        .reached_in(reached), .select_out(sel), .reach_rise_out(rises));

    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic close_out;
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), rdata, exp);
    endtask
    task automatic chk_spd(input logic [15:0] p, input logic [15:0] n);
        chk("pos speed limit", psl, p);
        chk("neg speed limit", nsl, n);
    endtask
    task automatic drive_ref(input logic [15:0] v, input logic e);
        @(posedge clk);
        tref <= v;
        settle;
        chk("torque reached", {15'h0000, reached}, {15'h0000, e});
    endtask

    task automatic t_regs;
        logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                                 8'h20, 8'h24};
        logic [15:0] rv [10] = '{16'h0BB8, 16'h0BB8, 16'h0000, 16'h0001, 16'h0BB8, 16'h0BB8,
                                 16'h0000, 16'h00C8, 16'h0064, 16'h000A};
        for (int i = 0; i < 10; i++) rd_chk(ra[i], rv[i]);
        wr_reg(8'h10, 16'h1B58);
        rd_chk(8'h10, 16'h1770);
        wr_reg(8'h24, 16'h0004);
        rd_chk(8'h24, 16'h0005);
        wr_reg(8'h24, 16'h0190);
        rd_chk(8'h24, 16'h012C);
        wr_reg(8'h00, 16'h0FA0);
        rd_chk(8'h00, 16'h0BB8);
        rd_chk(8'h40, 16'h0000);
    endtask
    task automatic t_torque;
        wr_reg(8'h00, 16'h03E8);
        wr_reg(8'h04, 16'h05DC);
        wr_reg(8'h28, 16'h0001);
        settle;
        chk("pos torque limit", ptl, 16'h03E8);
        chk("neg torque limit", ntl, 16'h05DC);
        wr_reg(8'h28, 16'h0003);
        settle;
        chk("pos torque limit", ptl, 16'h03E8);
        chk("neg torque limit", ntl, 16'h04B0);
        wr_reg(8'h00, 16'h0BB8);
        wr_reg(8'h28, 16'h0001);
        settle;
        chk("pos torque limit", ptl, 16'h09C4);
        wr_reg(8'h28, 16'h0002);
        settle;
        chk("neg torque limit", ntl, 16'h04B0);
        wr_reg(8'h2C, 16'h01F4);
        wr_reg(8'h28, 16'h0004);
        settle;
        chk("pos torque limit", ptl, 16'h01F4);
        chk("neg torque limit", ntl, 16'h09C4);
    endtask
    task automatic t_speed;
        wr_reg(8'h10, 16'h07D0);
        wr_reg(8'h14, 16'h05DC);
        settle;
        chk_spd(16'h07D0, 16'h05DC);
        wr_reg(8'h08, 16'h0001);
        settle;
        chk_spd(16'h03E8, 16'h03E8);
        wr_reg(8'h0C, 16'h0002);
        settle;
        chk_spd(16'h07D0, 16'h05DC);
        wr_reg(8'h08, 16'h0002);
        settle;
        chk_spd(16'h07D0, 16'h07D0);
        @(posedge clk);
        sel_req <= 1'b1;
        settle;
        chk_spd(16'h05DC, 16'h05DC);
        wr_reg(8'h08, 16'h0000);
        @(posedge clk);
        tmode <= 1'b1;
        sref  <= 16'h09C4;
        settle;
        chk("speed cmd", scmd, 16'h07D0);
        @(posedge clk);
        sref <= 16'hF8F8;
        settle;
        chk("speed cmd", scmd, 16'hFA24);
    endtask
    task automatic t_reach;
        wr_reg(8'h3C, 16'h0001);
        drive_ref(16'h00FA, 1'b1);
        chk("irq", {15'h0000, irq}, 16'h0001);
        drive_ref(16'h0096, 1'b1);
        drive_ref(16'h0063, 1'b0);
        drive_ref(16'h00C7, 1'b0);
        drive_ref(16'hFF38, 1'b1);
        wr_reg(8'h38, 16'h0001);
        settle;
        chk("irq", {15'h0000, irq}, 16'h0000);
        rd_chk(8'h38, 16'h0000);
        wr_reg(8'h18, 16'h0064);
        drive_ref(16'hFF38, 1'b1);
        drive_ref(16'h00C7, 1'b0);
        chk("reach rises", {8'h00, rises}, 16'h0002);
    endtask
    task automatic t_limit;
        int n;
        wr_reg(8'h24, 16'h0005);
        @(posedge clk);
        son  <= 1'b1;
        mspd <= 16'h07D1;
        repeat (10000) @(posedge clk);
        mspd <= 16'h07D0;
        @(posedge clk);
        mspd <= 16'h07D1;
        for (n = 0; n < 21000 && limited !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n >= 21000) begin
            fail_count++;
            close_out;
        end
        chk("limit delay", {15'h0000, n >= 19995 && n <= 20010}, 16'h0001);
        rd_chk(8'h34, 16'h0002);
        rd_chk(8'h38, 16'h0002);
        @(posedge clk);
        son <= 1'b0;
        settle;
        chk("speed limited", {15'h0000, limited}, 16'h0000);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_torque;
        t_speed;
        t_reach;
        t_limit;
        close_out;
    end
endmodule
`default_nettype wire

// File: core/slr_defines.vh
/*
 Constants of the servo limit and reach detect block: register offsets,
 reset values, setting ranges and timing counts.
 Assumes torque in 0.1 % steps of rated torque, speed in RPM, window in 0.1 ms.
*/
`ifndef SLR_DEFINES_VH
`define SLR_DEFINES_VH

// Register offsets
`define SLR_A_EXT_POS_TQ   8'h00
`define SLR_A_EXT_NEG_TQ   8'h04
`define SLR_A_SPD_SRC      8'h08
`define SLR_A_SPD_CHAN     8'h0C
`define SLR_A_POS_SPD      8'h10
`define SLR_A_NEG_SPD      8'h14
`define SLR_A_REACH_BASE   8'h18
`define SLR_A_REACH_ON     8'h1C
`define SLR_A_REACH_OFF    8'h20
`define SLR_A_QUAL_WIN     8'h24
`define SLR_A_TQ_SRC       8'h28
`define SLR_A_INT_POS_TQ   8'h2C
`define SLR_A_INT_NEG_TQ   8'h30
`define SLR_A_STATE        8'h34
`define SLR_A_IRQ_STAT     8'h38
`define SLR_A_IRQ_MASK     8'h3C

// Reset values
`define SLR_R_TQ_LIMIT     16'h0BB8
`define SLR_R_SPD_SRC      16'h0000
`define SLR_R_SPD_CHAN     16'h0001
`define SLR_R_SPD_LIMIT    16'h0BB8
`define SLR_R_REACH_BASE   16'h0000
`define SLR_R_REACH_ON     16'h00C8
`define SLR_R_REACH_OFF    16'h0064
`define SLR_R_QUAL_WIN     16'h000A
`define SLR_R_TQ_SRC       16'h0000

// Setting ranges
`define SLR_TQ_MAX_SET     16'h0BB8
`define SLR_SPD_MAX_SET    16'h1770
`define SLR_WIN_MIN_SET    16'h0005
`define SLR_WIN_MAX_SET    16'h012C
`define SLR_SPD_SRC_MAX    16'h0002
`define SLR_TQ_SRC_MAX     16'h0004
`define SLR_RATED_TORQUE   16'h03E8

// Selector codes
`define SLR_SRC_INTERNAL   3'h0
`define SLR_SRC_EXTERNAL   3'h1
`define SLR_SRC_ANALOG     3'h2
`define SLR_SRC_MIN_EXT    3'h3
`define SLR_CHAN_TWO       2'h2

// Interrupt status bits
`define SLR_IRQ_REACHED    0
`define SLR_IRQ_LIMITED    1

// Timing: clock period and window step, both in ns
`define SLR_CLK_NS         25
`define SLR_STEP_NS        100000
`define SLR_STEP_CYC       (`SLR_STEP_NS / `SLR_CLK_NS)

`endif

// File: core/slr_top.v
/*
 Servo limit selection with torque-reached and speed-limited detection.
 Assumes all inputs synchronous to CLK_SYS_IN; torque in 0.1 % of rated,
 speed in RPM; registers over a plain strobe port with read data one cycle later.
*/
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "slr_defines.vh"

module slr_top #(
    parameter [15:0] MAX_TORQUE = 16'h0BB8
) (
    // Clock and reset
    input  wire        CLK_SYS_IN,
    input  wire        RST_N_IN,
    // Register port
    input  wire [7:0]  ADDR_IN,
    input  wire [15:0] WDATA_IN,
    input  wire        WR_IN,
    input  wire        RD_IN,
    output reg  [15:0] RDATA_OUT,
    // Drive state
    input  wire        TORQUE_MODE_IN,
    input  wire        SERVO_ON_IN,
    input  wire        SPEED_LIMIT_SELECT_IN,
    input  wire signed [15:0] TORQUE_REF_IN,
    input  wire signed [15:0] MOTOR_SPEED_IN,
    input  wire signed [15:0] SPEED_REF_IN,
    // Analog inputs
    input  wire [15:0] ANALOG_INPUT_ONE_IN,
    input  wire [15:0] ANALOG_INPUT_TWO_IN,
    input  wire [15:0] ANALOG_TORQUE_LIMIT_IN,
    // Limits and status
    output reg  [15:0] POS_TORQUE_LIMIT_OUT,
    output reg  [15:0] NEG_TORQUE_LIMIT_OUT,
    output reg  [15:0] POS_SPEED_LIMIT_OUT,
    output reg  [15:0] NEG_SPEED_LIMIT_OUT,
    output reg signed [15:0] SPEED_CMD_OUT,
    output reg         TORQUE_REACHED_OUT,
    output reg         SPEED_LIMITED_OUT,
    output reg         IRQ_OUT
);

    function [15:0] min16;
        input [15:0] a;
        input [15:0] b;
        begin
            min16 = (a < b) ? a : b;
        end
    endfunction

    function [15:0] clamp16;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (v < lo) begin
                clamp16 = lo;
            end else if (v > hi) begin
                clamp16 = hi;
            end else begin
                clamp16 = v;
            end
        end
    endfunction

    function [15:0] abs16;
        input [15:0] v;
        begin
            abs16 = v[15] ? (~v + 16'h0001) : v;
        end
    endfunction

    localparam integer STEP_FULL = `SLR_STEP_CYC;
    localparam [11:0]  STEP_CYC  = STEP_FULL[11:0];
    localparam [15:0]  TQ_RESET  = (`SLR_R_TQ_LIMIT < MAX_TORQUE) ? `SLR_R_TQ_LIMIT : MAX_TORQUE;

    reg [15:0] ext_pos_tq_q;
    reg [15:0] ext_neg_tq_q;
    reg [15:0] spd_src_q;
    reg [15:0] spd_chan_q;
    reg [15:0] pos_spd_q;
    reg [15:0] neg_spd_q;
    reg [15:0] reach_base_q;
    reg [15:0] reach_on_q;
    reg [15:0] reach_off_q;
    reg [15:0] qual_win_q;
    reg [15:0] tq_src_q;
    reg [15:0] int_pos_tq_q;
    reg [15:0] int_neg_tq_q;
    reg [1:0]  irq_stat_q;
    reg [1:0]  irq_mask_q;
    reg [11:0] step_q;
    reg [15:0] win_cnt_q;

    reg [15:0] tq_pos_d;
    reg [15:0] tq_neg_d;
    reg [15:0] spd_pos_d;
    reg [15:0] spd_neg_d;
    reg [15:0] ai_spd;
    reg [15:0] rdata_d;
    reg [1:0]  irq_stat_d;
    reg [1:0]  irq_mask_d;

    wire        wr_ext_pos = WR_IN && (ADDR_IN == `SLR_A_EXT_POS_TQ);
    wire [15:0] tq_abs     = abs16(TORQUE_REF_IN);
    wire [15:0] spd_abs    = abs16(MOTOR_SPEED_IN);
    wire [16:0] reach_on   = {1'b0, reach_base_q} + {1'b0, reach_on_q};
    wire [16:0] reach_off  = {1'b0, reach_base_q} + {1'b0, reach_off_q};
    wire [15:0] spd_lim    = MOTOR_SPEED_IN[15] ? NEG_SPEED_LIMIT_OUT : POS_SPEED_LIMIT_OUT;
    wire        judge      = TORQUE_MODE_IN && SERVO_ON_IN;
    wire        over       = judge && (spd_abs > spd_lim);
    wire        step_tick  = (step_q == STEP_CYC - 12'h001);
    wire        reach_d;
    wire        limited_d;

    assign reach_d = TORQUE_REACHED_OUT ? ({1'b0, tq_abs} >= reach_off)
                                        : ({1'b0, tq_abs} >= reach_on);
    assign limited_d = over && (win_cnt_q >= qual_win_q);

    // Torque limit selection
    always @* begin
        case (tq_src_q[2:0])
            // external limits for source 1; source 3 takes the lower of external and analog
            `SLR_SRC_EXTERNAL: begin
                tq_pos_d = ext_pos_tq_q;
                tq_neg_d = ext_neg_tq_q;
            end
            `SLR_SRC_ANALOG: begin
                tq_pos_d = ANALOG_TORQUE_LIMIT_IN;
                tq_neg_d = ANALOG_TORQUE_LIMIT_IN;
            end
            `SLR_SRC_MIN_EXT: begin
                tq_pos_d = min16(ext_pos_tq_q, ANALOG_TORQUE_LIMIT_IN);
                tq_neg_d = min16(ext_neg_tq_q, ANALOG_TORQUE_LIMIT_IN);
            end
            default: begin
                tq_pos_d = int_pos_tq_q;
                tq_neg_d = int_neg_tq_q;
            end
        endcase
        tq_pos_d = min16(tq_pos_d, MAX_TORQUE);
        tq_neg_d = min16(tq_neg_d, MAX_TORQUE);
    end

    // Speed limit selection
    always @* begin
        ai_spd = (spd_chan_q[1:0] == `SLR_CHAN_TWO) ? ANALOG_INPUT_TWO_IN
                                                   : ANALOG_INPUT_ONE_IN;
        case (spd_src_q[1:0])
            2'h1: begin
                spd_pos_d = min16(ai_spd, pos_spd_q);
                spd_neg_d = min16(ai_spd, neg_spd_q);
            end
            2'h2: begin
                spd_pos_d = SPEED_LIMIT_SELECT_IN ? neg_spd_q : pos_spd_q;
                spd_neg_d = spd_pos_d;
            end
            default: begin
                spd_pos_d = pos_spd_q;
                spd_neg_d = neg_spd_q;
            end
        endcase
    end

    // Read mux
    always @* begin
        case (ADDR_IN)
            `SLR_A_EXT_POS_TQ: rdata_d = ext_pos_tq_q;
            `SLR_A_EXT_NEG_TQ: rdata_d = ext_neg_tq_q;
            `SLR_A_SPD_SRC:    rdata_d = spd_src_q;
            `SLR_A_SPD_CHAN:   rdata_d = spd_chan_q;
            `SLR_A_POS_SPD:    rdata_d = pos_spd_q;
            `SLR_A_NEG_SPD:    rdata_d = neg_spd_q;
            `SLR_A_REACH_BASE: rdata_d = reach_base_q;
            `SLR_A_REACH_ON:   rdata_d = reach_on_q;
            `SLR_A_REACH_OFF:  rdata_d = reach_off_q;
            `SLR_A_QUAL_WIN:   rdata_d = qual_win_q;
            `SLR_A_TQ_SRC:     rdata_d = tq_src_q;
            `SLR_A_INT_POS_TQ: rdata_d = int_pos_tq_q;
            `SLR_A_INT_NEG_TQ: rdata_d = int_neg_tq_q;
            `SLR_A_STATE:      rdata_d = {14'h0000, SPEED_LIMITED_OUT, TORQUE_REACHED_OUT};
            `SLR_A_IRQ_STAT:   rdata_d = {14'h0000, irq_stat_q};
            `SLR_A_IRQ_MASK:   rdata_d = {14'h0000, irq_mask_q};
            default:           rdata_d = 16'h0000;
        endcase
    end

    // Sticky events, set wins over clear
    always @* begin
        irq_stat_d = irq_stat_q;
        if (WR_IN && (ADDR_IN == `SLR_A_IRQ_STAT)) begin
            irq_stat_d = irq_stat_q & ~WDATA_IN[1:0];
        end
        if (reach_d && !TORQUE_REACHED_OUT) begin
            irq_stat_d[`SLR_IRQ_REACHED] = 1'b1;
        end
        if (limited_d && !SPEED_LIMITED_OUT) begin
            irq_stat_d[`SLR_IRQ_LIMITED] = 1'b1;
        end
    end

    // Mask as it stands after this cycle's write
    always @* begin
        irq_mask_d = irq_mask_q;
        if (WR_IN && (ADDR_IN == `SLR_A_IRQ_MASK)) begin
            irq_mask_d = WDATA_IN[1:0];
        end
    end

    // Settings registers
    always @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            ext_pos_tq_q <= `SLR_R_TQ_LIMIT;
            ext_neg_tq_q <= `SLR_R_TQ_LIMIT;
            spd_src_q    <= `SLR_R_SPD_SRC;
            spd_chan_q   <= `SLR_R_SPD_CHAN;
            pos_spd_q    <= `SLR_R_SPD_LIMIT;
            neg_spd_q    <= `SLR_R_SPD_LIMIT;
            reach_base_q <= `SLR_R_REACH_BASE;
            reach_on_q   <= `SLR_R_REACH_ON;
            reach_off_q  <= `SLR_R_REACH_OFF;
            qual_win_q   <= `SLR_R_QUAL_WIN;
            tq_src_q     <= `SLR_R_TQ_SRC;
            int_pos_tq_q <= `SLR_R_TQ_LIMIT;
            int_neg_tq_q <= `SLR_R_TQ_LIMIT;
            irq_mask_q   <= 2'h0;
        end else if (WR_IN) begin
            if (wr_ext_pos) begin
                ext_pos_tq_q <= min16(WDATA_IN, `SLR_TQ_MAX_SET);
            end
            if (ADDR_IN == `SLR_A_EXT_NEG_TQ) begin
                ext_neg_tq_q <= min16(WDATA_IN, `SLR_TQ_MAX_SET);
            end
            if (ADDR_IN == `SLR_A_SPD_SRC) begin
                spd_src_q <= min16(WDATA_IN, `SLR_SPD_SRC_MAX);
            end
            if (ADDR_IN == `SLR_A_SPD_CHAN) begin
                spd_chan_q <= clamp16(WDATA_IN, 16'h0001, 16'h0002);
            end
            if (ADDR_IN == `SLR_A_POS_SPD) begin
                pos_spd_q <= min16(WDATA_IN, `SLR_SPD_MAX_SET);
            end
            if (ADDR_IN == `SLR_A_NEG_SPD) begin
                neg_spd_q <= min16(WDATA_IN, `SLR_SPD_MAX_SET);
            end
            if (ADDR_IN == `SLR_A_REACH_BASE) begin
                reach_base_q <= min16(WDATA_IN, `SLR_TQ_MAX_SET);
            end
            if (ADDR_IN == `SLR_A_REACH_ON) begin
                reach_on_q <= min16(WDATA_IN, `SLR_TQ_MAX_SET);
            end
            if (ADDR_IN == `SLR_A_REACH_OFF) begin
                reach_off_q <= min16(WDATA_IN, `SLR_TQ_MAX_SET);
            end
            if (ADDR_IN == `SLR_A_QUAL_WIN) begin
                qual_win_q <= clamp16(WDATA_IN, `SLR_WIN_MIN_SET, `SLR_WIN_MAX_SET);
            end
            if (ADDR_IN == `SLR_A_TQ_SRC) begin
                tq_src_q <= min16(WDATA_IN, `SLR_TQ_SRC_MAX);
            end
            if (ADDR_IN == `SLR_A_INT_POS_TQ) begin
                int_pos_tq_q <= min16(WDATA_IN, `SLR_TQ_MAX_SET);
            end
            if (ADDR_IN == `SLR_A_INT_NEG_TQ) begin
                int_neg_tq_q <= min16(WDATA_IN, `SLR_TQ_MAX_SET);
            end
            if (ADDR_IN == `SLR_A_IRQ_MASK) begin
                irq_mask_q <= WDATA_IN[1:0];
            end
        end
    end

    // Window timing
    always @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            step_q    <= 12'h000;
            win_cnt_q <= 16'h0000;
        end else if (!over) begin
            step_q    <= 12'h000;
            win_cnt_q <= 16'h0000;
        end else if (step_tick) begin
            step_q <= 12'h000;
            if (win_cnt_q != 16'hFFFF) begin
                win_cnt_q <= win_cnt_q + 16'h0001;
            end
        end else begin
            step_q <= step_q + 12'h001;
        end
    end

    // Outputs
    always @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            RDATA_OUT            <= 16'h0000;
            POS_TORQUE_LIMIT_OUT <= TQ_RESET;
            NEG_TORQUE_LIMIT_OUT <= TQ_RESET;
            POS_SPEED_LIMIT_OUT  <= `SLR_R_SPD_LIMIT;
            NEG_SPEED_LIMIT_OUT  <= `SLR_R_SPD_LIMIT;
            SPEED_CMD_OUT        <= 16'h0000;
            TORQUE_REACHED_OUT   <= 1'b0;
            SPEED_LIMITED_OUT    <= 1'b0;
            irq_stat_q           <= 2'h0;
            IRQ_OUT              <= 1'b0;
        end else begin
            RDATA_OUT            <= RD_IN ? rdata_d : 16'h0000;
            POS_TORQUE_LIMIT_OUT <= tq_pos_d;
            NEG_TORQUE_LIMIT_OUT <= tq_neg_d;
            POS_SPEED_LIMIT_OUT  <= spd_pos_d;
            NEG_SPEED_LIMIT_OUT  <= spd_neg_d;
            if (!TORQUE_MODE_IN) begin
                SPEED_CMD_OUT <= SPEED_REF_IN;
            end else if (!SPEED_REF_IN[15] && (SPEED_REF_IN > $signed(spd_pos_d))) begin
                SPEED_CMD_OUT <= spd_pos_d;
            end else if (SPEED_REF_IN[15] && (abs16(SPEED_REF_IN) > spd_neg_d)) begin
                SPEED_CMD_OUT <= ~spd_neg_d + 16'h0001;
            end else begin
                SPEED_CMD_OUT <= SPEED_REF_IN;
            end
            TORQUE_REACHED_OUT   <= reach_d;
            SPEED_LIMITED_OUT    <= limited_d;
            irq_stat_q           <= irq_stat_d;
            IRQ_OUT              <= |(irq_stat_d & irq_mask_d);
        end
    end

endmodule

`default_nettype wire
